// ---- design/ctb_timebase.sv ----
// counter array main time base with an axi4-lite register slave
//
// How it works
// - 16-bit roll to zero sets overflow flag
// - byte-wrap option: overflow every 256 counts
// - enable cleared stops and zeroes the count
// - while disabled, the active compare value loads from its buffer
// - count equals compare value sets equal flag while enabled
// - equal irq enable gates the equal request
// - comparator event snapshots count when enabled
// - trigger disabled: comparator event takes no snapshot
// - module events set sticky module flags
// - count bytes readable, writes to them ignored
// - low byte read snapshots both bytes
// - upper reload byte loads upper count
// - lower reload byte loads lower count
// - upper snapshot read returns captured byte
// - upper snapshot write loads compare upper
// - auto-reload reloads at overflow, else wraps
// - eight-bit select makes an 8-bit counter
// - count rate is clock over divider plus one
// - lower snapshot reads low, write loads compare
//
// The AXI4-Lite slave port was chosen for this implementation.
`default_nettype none
`include "ctb_cfg.svh"

module ctb_timebase #(
    parameter int ADDR_W = `CTB_ADDR_W  // byte address width
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // axi4-lite write response
    output ctb_pkg::ctb_resp_type     s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // axi4-lite read data
    output logic [31:0]               s_axi_rdata,
    output ctb_pkg::ctb_resp_type     s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // on-chip inputs on aclk: cpu_idle is a level, events are one-cycle pulses
    input  wire logic                 cpu_idle,
    input  wire logic                 comparator_event,
    input  wire logic [5:0]           module_event,
    // time base towards the capture/compare modules
    output ctb_pkg::ctb_count_type    count_value,
    output logic                      overflow_pulse,
    // interrupt requests
    output logic                      overflow_irq,
    output logic                      count_equal_irq
);
    import ctb_pkg::*;

    // refuse an address too narrow for the highest register
    if (ADDR_W < `CTB_ADDR_W) begin : g_chk
        $error("ctb_timebase: ADDR_W too small");
    end

    ////////////////////////////////////////////////////////////////
    // register storage

    ctb_byte_type  mode;          // control bits
    ctb_byte_type  flags;         // sticky event flags
    ctb_byte_type  divider;       // input divider value
    ctb_byte_type  reload_lower;  // lower reload byte
    ctb_byte_type  reload_upper;  // upper reload byte
    ctb_count_type count;         // main count
    ctb_count_type snapshot;      // captured count
    ctb_count_type cmp_buffer;    // written compare value
    ctb_count_type cmp_active;    // compare value in use
    ctb_byte_type  div_count;     // prescaler position

    // control bits decoded from the mode register
    wire logic idle_stop      = mode[`CTB_M_IDLE];
    wire logic auto_reload    = mode[`CTB_M_RLD];
    wire logic eight_bit_sel  = mode[`CTB_M_CNT8];
    wire logic byte_wrap      = mode[`CTB_M_WRAP8];
    wire logic counter_enable = mode[`CTB_M_EN];
    wire logic ovf_irq_en     = mode[`CTB_M_OVFIE];
    wire logic eq_irq_en      = mode[`CTB_M_EQIE];
    wire logic trig_en        = mode[`CTB_M_TRIG];

    ////////////////////////////////////////////////////////////////
    // axi4-lite write side

    logic [ADDR_W-1:0] wr_addr;   // held write address
    logic [31:0]       wr_data;   // held write data
    logic              wr_lane0;  // held strobe for byte 0
    logic              aw_got;    // address is held
    logic              w_got;     // data is held

    // both halves held and no response pending: perform the write
    wire logic do_write = aw_got & w_got & ~s_axi_bvalid;
    wire logic wr_take  = do_write & wr_lane0;
    wire ctb_byte_type wr_byte = wr_data[7:0];

    // write decode
    wire logic wr_mode  = wr_take & (wr_addr == `CTB_A_MODE);
    wire logic wr_flags = wr_take & (wr_addr == `CTB_A_FLAGS);
    wire logic wr_div   = wr_take & (wr_addr == `CTB_A_DIV);
    wire logic wr_rldl  = wr_take & (wr_addr == `CTB_A_RLDL);
    wire logic wr_rldh  = wr_take & (wr_addr == `CTB_A_RLDH);
    wire logic wr_cmpl  = wr_take & (wr_addr == `CTB_A_SNAPL);
    wire logic wr_cmph  = wr_take & (wr_addr == `CTB_A_SNAPH);

    // every known address answers okay; writes to count bytes vanish
    wire logic wr_known = (wr_addr == `CTB_A_MODE)
                        | (wr_addr == `CTB_A_LOW)
                        | (wr_addr == `CTB_A_FLAGS)
                        | (wr_addr == `CTB_A_HIGH)
                        | (wr_addr == `CTB_A_SNAPL)
                        | (wr_addr == `CTB_A_SNAPH)
                        | (wr_addr == `CTB_A_DIV)
                        | (wr_addr == `CTB_A_RLDL)
                        | (wr_addr == `CTB_A_RLDH);

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_got        <= 1'b0;
            wr_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got        <= 1'b1;
            wr_addr       <= s_axi_awaddr;
        end else if (do_write) begin
            aw_got        <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_got        <= 1'b0;
            wr_data      <= '0;
            wr_lane0     <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got        <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_lane0     <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_got        <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CTB_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `CTB_OKAY : `CTB_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // axi4-lite read side

    wire logic rd_take = s_axi_arvalid & s_axi_arready;

    // read decode and data selection
    wire logic rd_low = rd_take & (s_axi_araddr == `CTB_A_LOW);
    logic [8:0] rd_sel;  // selected byte plus hit bit
    always_comb begin
        unique case (s_axi_araddr)
            `CTB_A_MODE:  rd_sel = {1'b1, mode};
            `CTB_A_LOW:   rd_sel = {1'b1, count[7:0]};
            `CTB_A_FLAGS: rd_sel = {1'b1, flags};
            `CTB_A_HIGH:  rd_sel = {1'b1, count[15:8]};
            `CTB_A_SNAPL: rd_sel = {1'b1, snapshot[7:0]};
            `CTB_A_SNAPH: rd_sel = {1'b1, snapshot[15:8]};
            `CTB_A_DIV:   rd_sel = {1'b1, divider};
            `CTB_A_RLDL:  rd_sel = {1'b1, reload_lower};
            `CTB_A_RLDH:  rd_sel = {1'b1, reload_upper};
            default:      rd_sel = 9'h000;
        endcase
    end

    // read channel: data registered at the accepting edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `CTB_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_sel[7:0]};
            s_axi_rresp   <= rd_sel[8] ? `CTB_OKAY : `CTB_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // prescaler and counting

    // counting runs when enabled and not held by idle
    wire logic run = counter_enable & ~(idle_stop & cpu_idle);

    // one pulse every divider+1 clocks
    wire logic tick = run & (div_count == divider);

    // prescaler restarts whenever the counter is halted
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || tick) begin
            div_count <= `CTB_RST_BYTE;
        end else begin
            div_count <= div_count + 8'h01;
        end
    end

    // wrap points of the low byte and the whole count
    wire logic wrap8  = tick & (count[7:0] == `CTB_ONES8);
    wire logic wrap16 = tick & (count == `CTB_ONES16);

    // overflow: every 256 counts with byte-wrap or in 8-bit mode
    wire logic ovf = (byte_wrap | eight_bit_sel)
                   ? wrap8
                   : wrap16;

    // next count value
    ctb_count_type next_count;
    always_comb begin
        next_count = count;
        if (!counter_enable) begin
            next_count = `CTB_RST_CNT;
        end else if (ovf && auto_reload) begin
            next_count[7:0] = reload_lower;
            if (!eight_bit_sel) begin
                next_count[15:8] = reload_upper;
            end
        end else if (tick && eight_bit_sel) begin
            next_count[7:0] = count[7:0] + 8'h01;
        end else if (tick) begin
            next_count = count + `CTB_ONE16;
        end
    end

    // main count register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= `CTB_RST_CNT;
        end else begin
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////
    // compare value, double buffered

    // buffer written through the snapshot addresses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_buffer <= `CTB_RST_CNT;
        end else begin
            if (wr_cmpl) begin
                cmp_buffer[7:0] <= wr_byte;
            end
            if (wr_cmph) begin
                cmp_buffer[15:8] <= wr_byte;
            end
        end
    end

    // active value follows the buffer at overflow or while disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_active <= `CTB_RST_CNT;
        end else if (!counter_enable || ovf) begin
            cmp_active <= cmp_buffer;
        end
    end

    // equality is judged only while the counter is enabled
    wire logic equal_hit = counter_enable & (count == cmp_active);

    ////////////////////////////////////////////////////////////////
    // snapshot of the count

    // low byte read, or comparator event when enabled
    wire logic snap_cmp  = comparator_event & trig_en;
    wire logic snap_take = rd_low | snap_cmp;

    // captured count, never written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snapshot <= `CTB_RST_CNT;
        end else if (snap_take) begin
            snapshot <= count;
        end
    end

    ////////////////////////////////////////////////////////////////
    // control registers

    // mode, divider and reload bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode         <= `CTB_RST_BYTE;
            divider      <= `CTB_RST_BYTE;
            reload_lower <= `CTB_RST_BYTE;
            reload_upper <= `CTB_RST_BYTE;
        end else begin
            if (wr_mode) begin
                mode <= wr_byte;
            end
            if (wr_div) begin
                divider <= wr_byte;
            end
            if (wr_rldl) begin
                reload_lower <= wr_byte;
            end
            if (wr_rldh) begin
                reload_upper <= wr_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // sticky flags: a hardware set wins over a software clear

    ctb_byte_type flag_set;   // events of this cycle
    ctb_byte_type next_flags; // written value merged with events
    always_comb begin
        flag_set              = {2'b00, module_event};
        flag_set[`CTB_F_OVF]  = ovf;
        flag_set[`CTB_F_EQ]   = equal_hit;
        next_flags = (wr_flags ? wr_byte : flags) | flag_set;
    end

    // flags register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= `CTB_RST_BYTE;
        end else begin
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs towards modules and interrupt requests

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value     <= `CTB_RST_CNT;
            overflow_pulse  <= 1'b0;
            overflow_irq    <= 1'b0;
            count_equal_irq <= 1'b0;
        end else begin
            count_value     <= next_count;
            overflow_pulse  <= ovf;
            overflow_irq    <= next_flags[`CTB_F_OVF] & ovf_irq_en;
            count_equal_irq <= next_flags[`CTB_F_EQ] & eq_irq_en;
        end
    end

endmodule
`default_nettype wire

// ---- shared/ctb_cfg.svh ----
// offsets, field positions, reset values and sizes of the time base
`ifndef CTB_CFG_SVH
`define CTB_CFG_SVH

// register indexes as printed; byte address is four times the index
`define CTB_I_MODE   16'h00D1
`define CTB_I_LOW    16'h00D9
`define CTB_I_FLAGS  16'h00E1
`define CTB_I_HIGH   16'h00E9
`define CTB_I_SNAPL  16'h00F2
`define CTB_I_SNAPH  16'h00F3
`define CTB_I_DIV    16'hA0A5
`define CTB_I_RLDL   16'hA0A6
`define CTB_I_RLDH   16'hA0A7
`define CTB_ADDR_W   18
`define CTB_A_MODE   {`CTB_I_MODE, 2'b00}
`define CTB_A_LOW    {`CTB_I_LOW, 2'b00}
`define CTB_A_FLAGS  {`CTB_I_FLAGS, 2'b00}
`define CTB_A_HIGH   {`CTB_I_HIGH, 2'b00}
`define CTB_A_SNAPL  {`CTB_I_SNAPL, 2'b00}
`define CTB_A_SNAPH  {`CTB_I_SNAPH, 2'b00}
`define CTB_A_DIV    {`CTB_I_DIV, 2'b00}
`define CTB_A_RLDL   {`CTB_I_RLDL, 2'b00}
`define CTB_A_RLDH   {`CTB_I_RLDH, 2'b00}

// mode register bit positions
`define CTB_M_IDLE   7
`define CTB_M_RLD    6
`define CTB_M_CNT8   5
`define CTB_M_WRAP8  4
`define CTB_M_EN     3
`define CTB_M_OVFIE  2
`define CTB_M_EQIE   1
`define CTB_M_TRIG   0

// flags register bit positions
`define CTB_F_OVF    7
`define CTB_F_EQ     6

// reset values
`define CTB_RST_BYTE 8'h00
`define CTB_RST_CNT  16'h0000

// counter wrap points
`define CTB_ONES8    8'hFF
`define CTB_ONES16   16'hFFFF
`define CTB_ONE16    16'h0001

// bus answers
`define CTB_OKAY     2'h0
`define CTB_DECERR   2'h3

`endif

// ---- shared/ctb_pkg.sv ----
// types shared by the counter array time base
`default_nettype none
package ctb_pkg;
    typedef logic [1:0]  ctb_resp_type;   // axi response code
    typedef logic [7:0]  ctb_byte_type;   // one register byte
    typedef logic [15:0] ctb_count_type;  // main count
endpackage
`default_nettype wire

// ---- tb/counter_array_main_timebase_tb_top.sv ----
// self-checking bench for the counter array time base
`default_nettype none
`include "ctb_cfg.svh"
module counter_array_main_timebase_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ctb_pkg::*;
    logic          aclk, aresetn, cpu_idle, comparator_event;
    logic [17:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata;
    logic [3:0]    s_axi_wstrb;
    logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic          s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic          s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    ctb_resp_type  s_axi_bresp, s_axi_rresp;
    ctb_count_type count_value;
    logic          overflow_pulse, overflow_irq, count_equal_irq;
    logic [5:0]    module_event;
    int            err_total, samples_checked, seed, i;
    logic [9:0]    rq[$];   // expected {resp, byte} of each read
    ctb_resp_type  bq[$];   // expected response of each write
    logic [9:0]    exp_r;
    logic [7:0]    rl, rh, cl;
    logic [15:0]   nn, mm;
    logic [15:0]   idx_tab[9] = '{`CTB_I_MODE, `CTB_I_LOW, `CTB_I_FLAGS,
        `CTB_I_HIGH, `CTB_I_SNAPL, `CTB_I_SNAPH, `CTB_I_DIV, `CTB_I_RLDL,
        `CTB_I_RLDH};

    ctb_timebase dut (.*);

    // free running bus clock
    always #12.5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////
    // compare one value, count and report
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // verdict and end of run
    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // register write, response noted for the monitor
    task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                      input ctb_resp_type r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        bq.push_back(r);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    // register read, expected byte noted for the monitor
    task automatic rd(input logic [15:0] idx, input logic [7:0] e,
                      input ctb_resp_type r);
        rq.push_back({r, e});
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // bounded wait for the overflow pulse
    task automatic wait_pulse(input int lim);
        int k;
        for (k = 0; k < lim && overflow_pulse !== 1'b1; k++)
            @(posedge aclk);
        chk("ovf_pulse", 16'h0001, {15'h0000, overflow_pulse});
    endtask
    // let the gated counter run for n clocks
    task automatic run_free(input logic [15:0] n);
        cpu_idle <= 1'b0;
        repeat (n) @(posedge aclk);
        cpu_idle <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////
    // monitors take the oldest note whenever an answer is taken
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", bq.pop_front(), s_axi_bresp);
        if (s_axi_rvalid && s_axi_rready) begin
            exp_r = rq.pop_front();
            chk("rdata", {8'h00, exp_r[7:0]}, s_axi_rdata[15:0]);
            chk("rresp", exp_r[9:8], s_axi_rresp);
        end
    end
    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge aclk);
        err_total++;
        print_verdict();
    end
    // main sequence
    initial begin
        {aclk, aresetn, cpu_idle, comparator_event, module_event} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {err_total, samples_checked} = '0;
        seed = 57;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values, unmapped place
        foreach (idx_tab[i]) rd(idx_tab[i], 8'h00, `CTB_OKAY);
        rd(16'h0001, 8'h00, `CTB_DECERR);
        wr(16'h0001, 8'h5A, `CTB_DECERR);
        // reload and divider registers, strobe off leaves the lower reload byte alone
        rl = 8'($random(seed)) & 8'h7F;
        rh = 8'($random(seed));
        wr(`CTB_I_RLDL, rl, `CTB_OKAY);
        wr(`CTB_I_RLDH, rh, `CTB_OKAY);
        wr(`CTB_I_DIV, 8'h03, `CTB_OKAY);
        s_axi_wstrb <= 4'h0;
        wr(`CTB_I_RLDL, ~rl, `CTB_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`CTB_I_RLDL, rl, `CTB_OKAY);
        rd(`CTB_I_RLDH, rh, `CTB_OKAY);
        // module events set sticky flags, software clears
        module_event <= 6'($random(seed)) | 6'h01;
        @(posedge aclk);
        rd(`CTB_I_FLAGS, {2'b00, module_event}, `CTB_OKAY);
        module_event <= 6'h00;
        wr(`CTB_I_FLAGS, 8'h00, `CTB_OKAY);
        rd(`CTB_I_FLAGS, 8'h00, `CTB_OKAY);
        // eight-bit mode, reload of the low byte, tick spacing
        wr(`CTB_I_MODE, 8'h78, `CTB_OKAY);
        wait_pulse(1200);
        chk("eight_bit_select", {8'h00, rl}, count_value);
        repeat (3) @(posedge aclk);
        chk("tick_hold", {8'h00, rl}, count_value);
        @(posedge aclk);
        chk("tick_step", {8'h00, rl + 8'h01}, count_value);
        // disable zeroes the count
        wr(`CTB_I_MODE, 8'h00, `CTB_OKAY);
        @(posedge aclk);
        chk("count_off", 16'h0000, count_value);
        // byte wrap in 16-bit mode reloads both bytes
        wr(`CTB_I_MODE, 8'h58, `CTB_OKAY);
        wait_pulse(1200);
        chk("count16", {rh, rl}, count_value);
        // free 16-bit roll with compare loaded while disabled
        wr(`CTB_I_MODE, 8'h00, `CTB_OKAY);
        wr(`CTB_I_FLAGS, 8'h00, `CTB_OKAY);
        wr(`CTB_I_DIV, 8'h00, `CTB_OKAY);
        cl = (8'($random(seed)) & 8'h0E) | 8'h01;
        wr(`CTB_I_SNAPL, cl, `CTB_OKAY);
        wr(`CTB_I_SNAPH, 8'h00, `CTB_OKAY);
        wr(`CTB_I_MODE, 8'h0C, `CTB_OKAY);
        wait_pulse(70000);
        chk("ovf_irq", 16'h0001, overflow_irq);
        chk("eq_irq_off", 16'h0000, count_equal_irq);
        repeat (16) @(posedge aclk);
        rd(`CTB_I_FLAGS, 8'hC0, `CTB_OKAY);
        wr(`CTB_I_MODE, 8'h0E, `CTB_OKAY);
        repeat (2) @(posedge aclk);
        chk("eq_irq_on", 16'h0001, count_equal_irq);
        wr(`CTB_I_FLAGS, 8'h00, `CTB_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq_clear", 16'h0000, {overflow_irq, count_equal_irq});
        // idle-gated count to a known value, then snapshots
        wr(`CTB_I_MODE, 8'h00, `CTB_OKAY);
        cpu_idle <= 1'b1;
        wr(`CTB_I_MODE, 8'h88, `CTB_OKAY);
        nn = 16'd300 + 16'($random(seed) & 255);
        run_free(nn);
        comparator_event <= 1'b1;
        @(posedge aclk);
        comparator_event <= 1'b0;
        rd(`CTB_I_SNAPL, 8'h00, `CTB_OKAY);
        wr(`CTB_I_LOW, 8'hA5, `CTB_OKAY);
        wr(`CTB_I_HIGH, 8'h5A, `CTB_OKAY);
        rd(`CTB_I_LOW, nn[7:0], `CTB_OKAY);
        rd(`CTB_I_HIGH, nn[15:8], `CTB_OKAY);
        wr(`CTB_I_SNAPH, 8'hFF, `CTB_OKAY);
        rd(`CTB_I_SNAPH, nn[15:8], `CTB_OKAY);
        rd(`CTB_I_SNAPL, nn[7:0], `CTB_OKAY);
        wr(`CTB_I_MODE, 8'h89, `CTB_OKAY);
        mm = 16'($random(seed) & 63) + 16'd1;
        run_free(mm);
        comparator_event <= 1'b1;
        @(posedge aclk);
        comparator_event <= 1'b0;
        nn = nn + mm;
        rd(`CTB_I_SNAPL, nn[7:0], `CTB_OKAY);
        rd(`CTB_I_SNAPH, nn[15:8], `CTB_OKAY);
        print_verdict();
    end
endmodule

bind ctb_timebase ctb_timebase_props u_props (.*);
`default_nettype wire

// ---- tb/ctb_timebase_properties.sv ----
// concurrent checks on the ports of the counter array time base
`default_nettype none
module ctb_timebase_props (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire ctb_pkg::ctb_resp_type  s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire ctb_pkg::ctb_resp_type  s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire ctb_pkg::ctb_count_type count_value,
    input wire logic                   overflow_pulse,
    input wire logic                   overflow_irq,
    input wire logic                   count_equal_irq
);
    import ctb_pkg::*;
    // one clock domain, reset switches every check off
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    // overflow pulse only after the low byte wrapped
    ovf_cause_a: assert property (
        overflow_pulse |-> ($past(count_value, 1) & 16'h00FF) == 16'h00FF)
        else $error("overflow pulse without a low byte wrap");
    // a full 16-bit roll to zero raises the pulse next sample
    full_roll_a: assert property (
        count_value == 16'hFFFF ##1 count_value == 16'h0000 |-> overflow_pulse)
        else $error("no overflow pulse after the 16-bit roll");
    // the pulse lasts a single cycle
    pulse_single_a: assert property (
        overflow_pulse |=> !overflow_pulse)
        else $error("overflow pulse longer than one cycle");
    // requests only drop while a register write is in progress
    ovf_irq_sticky_a: assert property (
        $fell(overflow_irq) |-> !s_axi_awready || !$past(s_axi_awready))
        else $error("overflow request dropped without a write");
    eq_irq_sticky_a: assert property (
        $fell(count_equal_irq) |-> !s_axi_awready || !$past(s_axi_awready))
        else $error("equal request dropped without a write");
    // answers stand until taken
    b_stands_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response withdrawn early");
    r_stands_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data withdrawn early");
    // read taken: data next sample, no second read accepted
    r_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    b_answer_a: assert property (
        s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write answer late");
    // only the low byte carries data, refused reads return zero
    r_clean_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000
            && (s_axi_rresp != 2'h3 || s_axi_rdata[7:0] == 8'h00))
        else $error("read data outside the byte lane");
    // main scenarios reached
    cover property (overflow_pulse);
    cover property ($rose(overflow_irq));
    cover property ($rose(count_equal_irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule
`default_nettype wire
